// *** design/sip_power_reset.sv ***
`timescale 1ns/1ns
// Function
// [RQ1] core and peripheral clocks at half master rate
// [RQ2] core, memory, peripheral clocks share one rate
// [RQ3] peripherals bus clocked, each gateable; watchdog separate
// [RQ4] wait stops core clocks, keeps peripheral clocks
// [RQ5] unmasked peripheral interrupt wakes core from wait
// [RQ6] stop left only by listed wake sources
// [RQ7] software turns pll off itself before stop
// [RQ8] control register disables sleep instructions, temp/permanent
// [RQ9] four reset sources, two async, two sync; code has two async and three sync (power-on, software, watchdog)
// [RQ10] supply detectors drive power-on reset, hysteresis
// [RQ11] reset released in 64/32/32 clock stages
// [RQ12] reset released only on rising clock edge
// [RQ13] high register gives short address bits 23:22
// [RQ14] low register gives short address bits 21:6
// [RQ15] security from two non-volatile flash bytes
// [RQ16] boot picks unsecured or secure mode
// [RQ17] secure disables core debug, execution unaffected
// [RQ18] security bytes drive debug read disable at reset
// [RQ19] chip test access port active regardless of security
// [RQ20] short address takes effect five cycles after write
// [RQ21] clock enable bit one supplies clock, zero withholds
// [RQ22] sleep instruction enters wait/stop unless disabled
// [RQ23] non-reset stop wake restores clocks, returns run
module sip_power_reset #(
  parameter int STAB_CYCLES   = sip_pkg::SIP_STAB_CYC,
  parameter int PERIPH_CYCLES = sip_pkg::SIP_PERIPH_CYC,
  parameter int CORE_CYCLES   = sip_pkg::SIP_CORE_CYC,
  parameter int SA_DELAY      = sip_pkg::SIP_SA_DELAY,
  parameter logic [15:0] SEC_ON_WORD = sip_pkg::SIP_SEC_ON_WORD
) (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          ext_reset_n_i,
  input  wire logic                          lv_core_1v8_i,
  input  wire logic                          lv_core_2v2_i,
  input  wire logic                          lv_io_2v7_i,
  input  wire logic                          watchdog_reset_i,
  input  wire logic                          wait_instr_i,
  input  wire logic                          stop_instr_i,
  input  wire logic                          periph_irq_i,
  input  wire logic                          can_activity_i,
  input  wire logic                          external_irq_a_i,
  input  wire logic [7:0]                    sec_byte_lo_i,
  input  wire logic [7:0]                    sec_byte_hi_i,
  input  wire logic [sip_pkg::SIP_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [sip_pkg::SIP_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [sip_pkg::SIP_DATA_W-1:0] avs_readdata_o,
  output logic                               avs_waitrequest_o,
  output logic                               core_clk_o,
  output logic [sip_pkg::SIP_REG_W-1:0]      periph_clk_o,
  output logic                               watchdog_clk_o,
  output logic                               clk_out_o,
  output logic                               debug_clk_o,
  output logic                               periph_rst_n_o,
  output logic                               core_rst_n_o,
  output logic                               app_run_o,
  output logic                               debug_read_dis_o,
  output logic                               debug_if_dis_o,
  output logic                               jtag_tap_en_o,
  output logic [sip_pkg::SIP_SA_BASE_W-1:0]  short_address_base_o,
  output logic [1:0]                         power_mode_o
);
  import sip_pkg::*;

  function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be,
                                           input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  // reset synchroniser: assertion is immediate, release waits for an edge
  logic rst_meta_r;
  logic rst_sync_r;
  wire  async_rst_n = reset_n_i & ext_reset_n_i; // RQ9

  always_ff @(posedge clock_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r; // RQ12
    end
  end

  wire rst_n = rst_sync_r;

  // bus slave: one wait cycle, then answer
  logic        ack_r;
  logic [31:0] rdata_r;
  wire         bus_req  = avs_read_i | avs_write_i;
  wire         wr_fire  = avs_write_i & ack_r;
  wire [15:0]  wdata    = avs_writedata_i[15:0];
  wire [1:0]   wbe      = avs_byteenable_i[1:0];
  wire         sel_ctrl = (avs_address_i == SIP_OFS_CTRL);
  wire         sel_pce  = (avs_address_i == SIP_OFS_PCE);
  wire         sel_sah  = (avs_address_i == SIP_OFS_SA_HIGH);
  wire         sel_sal  = (avs_address_i == SIP_OFS_SA_LOW);
  wire         sel_st   = (avs_address_i == SIP_OFS_STATUS);

  assign avs_waitrequest_o = bus_req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // registers
  logic [15:0] ctrl_r;
  logic [15:0] pce_r;
  logic [15:0] sah_r;
  logic [15:0] sal_r;
  sip_seq_t    seq_r;
  sip_seq_t    seq_nxt;
  sip_pm_t     pm_r;
  sip_pm_t     pm_nxt;
  logic [SIP_CNT_W-1:0] cnt_r;
  logic        por_active_r;
  logic        secure_r;
  logic        div_r;

  wire sw_reset  = wr_fire & sel_ctrl & wbe[0] & wdata[SIP_CTL_SW_RESET]; // RQ9
  wire seq_hold  = (seq_r == SEQ_HOLD);
  wire wait_dis  = ctrl_r[SIP_CTL_WAIT_TMP] | ctrl_r[SIP_CTL_WAIT_PERM];
  wire stop_dis  = ctrl_r[SIP_CTL_STOP_TMP] | ctrl_r[SIP_CTL_STOP_PERM];

  // permanent disables are set-only; only a reset clears them
  wire [15:0] ctrl_perm = ctrl_r & ((16'h0001 << SIP_CTL_WAIT_PERM)
                                  | (16'h0001 << SIP_CTL_STOP_PERM));
  wire [15:0] ctrl_wr   = be_merge(ctrl_r, wdata, wbe, SIP_CTRL_WMASK) | ctrl_perm; // RQ8

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= SIP_CTRL_RESET;
      pce_r  <= SIP_PCE_RESET;
      sah_r  <= SIP_SAH_RESET;
      sal_r  <= SIP_SAL_RESET;
    end else if (seq_hold) begin
      ctrl_r <= SIP_CTRL_RESET; // RQ8
      pce_r  <= SIP_PCE_RESET;
      sah_r  <= SIP_SAH_RESET;
      sal_r  <= SIP_SAL_RESET;
    end else if (wr_fire) begin
      if (sel_ctrl) ctrl_r <= ctrl_wr; // RQ8
      if (sel_pce)  pce_r  <= be_merge(pce_r, wdata, wbe, SIP_PCE_WMASK); // RQ21
      if (sel_sah)  sah_r  <= be_merge(sah_r, wdata, wbe, SIP_SAH_WMASK); // RQ13
      if (sel_sal)  sal_r  <= be_merge(sal_r, wdata, wbe, 16'hFFFF); // RQ14
    end
  end

  wire [15:0] status_w = {9'h000, stop_dis, wait_dis, (seq_r == SEQ_RUN),
                          por_active_r, secure_r, power_mode_o};
  wire [15:0] rd_mux = sel_ctrl ? ctrl_r :
                       sel_pce  ? pce_r  :
                       sel_sah  ? sah_r  :
                       sel_sal  ? sal_r  :
                       sel_st   ? status_w : 16'h0000;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= bus_req & ~ack_r;
      if (avs_read_i & ~ack_r) begin
        rdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  // power-on reset with hysteresis: only the lowest detector declares it
  wire lv_any = lv_core_1v8_i | lv_core_2v2_i | lv_io_2v7_i;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      por_active_r <= 1'b1;
    end else if (lv_core_1v8_i) begin
      por_active_r <= 1'b1; // RQ10
    end else if (!lv_any) begin
      por_active_r <= 1'b0; // RQ10
    end
  end

  // staged reset release
  wire sync_rst = por_active_r | sw_reset | watchdog_reset_i; // RQ9
  wire cnt_last_stab   = (cnt_r == SIP_CNT_W'(STAB_CYCLES - 1));
  wire cnt_last_periph = (cnt_r == SIP_CNT_W'(PERIPH_CYCLES - 1));
  wire cnt_last_core   = (cnt_r == SIP_CNT_W'(CORE_CYCLES - 1));

  always_comb begin
    seq_nxt = seq_r;
    if (sync_rst) begin
      seq_nxt = SEQ_HOLD;
    end else begin
      case (seq_r)
        SEQ_HOLD:   seq_nxt = SEQ_STAB;
        SEQ_STAB:   if (cnt_last_stab) seq_nxt = SEQ_PERIPH; // RQ11
        SEQ_PERIPH: if (cnt_last_periph) seq_nxt = SEQ_CORE; // RQ11
        SEQ_CORE:   if (cnt_last_core) seq_nxt = SEQ_RUN; // RQ11
        SEQ_RUN:    seq_nxt = SEQ_RUN;
        default:    seq_nxt = SEQ_HOLD;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= SEQ_HOLD;
      cnt_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      cnt_r <= (seq_nxt != seq_r) ? '0 : cnt_r + 1'b1;
    end
  end

  // security bytes are sampled when the flash window opens
  wire sec_sample = (seq_r == SEQ_STAB) && (seq_nxt == SEQ_PERIPH);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      secure_r <= 1'b1; // fail safe until the bytes are read
    end else if (sec_sample) begin
      secure_r <= ({sec_byte_hi_i, sec_byte_lo_i} == SEC_ON_WORD); // RQ15 RQ16
    end
  end

  // power modes
  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      PM_RUN: begin
        if (stop_instr_i && !stop_dis) pm_nxt = PM_STOP; // RQ22
        else if (wait_instr_i && !wait_dis) pm_nxt = PM_WAIT; // RQ22
      end
      PM_WAIT: if (periph_irq_i) pm_nxt = PM_RUN; // RQ5
      // first can frame only wakes the part and is not received
      PM_STOP: if (can_activity_i || external_irq_a_i) pm_nxt = PM_RUN; // RQ6 RQ23
      default: pm_nxt = PM_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pm_r <= PM_RUN;
    end else if (seq_r != SEQ_RUN) begin
      pm_r <= PM_RUN; // RQ6
    end else begin
      pm_r <= pm_nxt;
    end
  end

  // clocks: each output is a registered half-rate pulse; an enable change
  // only lands on an edge, so no pulse is ever cut short
  wire core_on   = (pm_r == PM_RUN) && (seq_r == SEQ_CORE || seq_r == SEQ_RUN); // RQ4
  wire periph_on = (pm_r != PM_STOP) && (seq_r != SEQ_HOLD); // RQ4

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_r          <= 1'b0;
      core_clk_o     <= 1'b0;
      periph_clk_o   <= '0;
      watchdog_clk_o <= 1'b0;
      clk_out_o      <= 1'b0;
      debug_clk_o    <= 1'b0;
    end else begin
      div_r          <= ~div_r; // RQ1
      core_clk_o     <= ~div_r & core_on; // RQ1 RQ2
      periph_clk_o   <= {SIP_REG_W{~div_r & periph_on}} & pce_r; // RQ2 RQ3 RQ21
      watchdog_clk_o <= ~div_r; // RQ3
      clk_out_o      <= ~div_r & ~ctrl_r[SIP_CTL_CLKO_DIS];
      debug_clk_o    <= ~div_r & ctrl_r[SIP_CTL_DBG_CLKEN] & ~secure_r; // RQ17
    end
  end

  // reset outputs and security interlock
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      periph_rst_n_o   <= 1'b0;
      core_rst_n_o     <= 1'b0;
      app_run_o        <= 1'b0;
      debug_read_dis_o <= 1'b1;
      debug_if_dis_o   <= 1'b1;
    end else begin
      periph_rst_n_o   <= (seq_nxt == SEQ_PERIPH) || (seq_nxt == SEQ_CORE)
                          || (seq_nxt == SEQ_RUN); // RQ11 RQ12
      core_rst_n_o     <= (seq_nxt == SEQ_CORE) || (seq_nxt == SEQ_RUN); // RQ11
      app_run_o        <= (seq_nxt == SEQ_RUN); // RQ11
      debug_read_dis_o <= secure_r; // RQ18
      debug_if_dis_o   <= secure_r; // RQ17
    end
  end

  // boundary scan stays reachable whatever the security state
  assign jtag_tap_en_o = 1'b1; // RQ19

  // short address base: pipelined so a new value lands five cycles late
  logic [SIP_SA_BASE_W-1:0] sa_pipe_r [SA_DELAY];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SA_DELAY; i++) begin
        sa_pipe_r[i] <= {SIP_SAH_RESET[1:0], SIP_SAL_RESET};
      end
    end else begin
      sa_pipe_r[0] <= {sah_r[1:0], sal_r}; // RQ13 RQ14
      for (int i = 1; i < SA_DELAY; i++) begin
        sa_pipe_r[i] <= sa_pipe_r[i-1]; // RQ20
      end
    end
  end

  assign short_address_base_o = sa_pipe_r[SA_DELAY-1]; // RQ20
  assign power_mode_o = (pm_r == PM_WAIT) ? SIP_MODE_WAIT :
                        (pm_r == PM_STOP) ? SIP_MODE_STOP : SIP_MODE_RUN;
endmodule : sip_power_reset

// *** common/sip_pkg.sv ***
package sip_pkg;
  localparam int          SIP_ADDR_W        = 5;
  localparam int          SIP_DATA_W        = 32;
  localparam int          SIP_REG_W         = 16;
  // byte addresses of the register words
  localparam logic [4:0]  SIP_OFS_CTRL      = 5'h00;
  localparam logic [4:0]  SIP_OFS_PCE       = 5'h04;
  localparam logic [4:0]  SIP_OFS_SA_HIGH   = 5'h08;
  localparam logic [4:0]  SIP_OFS_SA_LOW    = 5'h0C;
  localparam logic [4:0]  SIP_OFS_STATUS    = 5'h10;
  // system_control_reg fields
  localparam int          SIP_CTL_WAIT_TMP  = 0;
  localparam int          SIP_CTL_STOP_TMP  = 1;
  localparam int          SIP_CTL_WAIT_PERM = 2;
  localparam int          SIP_CTL_STOP_PERM = 3;
  localparam int          SIP_CTL_SW_RESET  = 4;
  localparam int          SIP_CTL_CLKO_DIS  = 5;
  localparam int          SIP_CTL_DBG_CLKEN = 6;
  localparam logic [15:0] SIP_CTRL_RESET    = 16'h0000;
  localparam logic [15:0] SIP_CTRL_WMASK    = 16'h006F;
  // peripheral_clock_gate_reg: reserved bits read one
  localparam logic [15:0] SIP_PCE_RESET     = 16'hFFFF;
  localparam logic [15:0] SIP_PCE_WMASK     = 16'h357D;
  // short address registers
  localparam logic [15:0] SIP_SAH_RESET     = 16'hFFFF;
  localparam logic [15:0] SIP_SAH_WMASK     = 16'h0003;
  localparam logic [15:0] SIP_SAL_RESET     = 16'hFFFF;
  localparam int          SIP_SA_BASE_W     = 18;
  // status fields
  localparam int          SIP_ST_MODE_LO    = 0;
  localparam int          SIP_ST_SECURE     = 2;
  localparam int          SIP_ST_POR        = 3;
  localparam int          SIP_ST_APP_RUN    = 4;
  localparam int          SIP_ST_WAIT_DIS   = 5;
  localparam int          SIP_ST_STOP_DIS   = 6;
  // reset sequence windows, in master clock cycles
  localparam int          SIP_STAB_CYC      = 64;
  localparam int          SIP_PERIPH_CYC    = 32;
  localparam int          SIP_CORE_CYC      = 32;
  localparam int          SIP_CNT_W         = 7;
  // short address pipeline depth
  localparam int          SIP_SA_DELAY      = 5;
  // security word that marks the part secured; value is arbitrary
  localparam logic [15:0] SIP_SEC_ON_WORD   = 16'hA55A;
  localparam logic [1:0]  SIP_MODE_RUN      = 2'h0;
  localparam logic [1:0]  SIP_MODE_WAIT     = 2'h1;
  localparam logic [1:0]  SIP_MODE_STOP     = 2'h2;

  typedef enum logic [2:0] {SEQ_HOLD, SEQ_STAB, SEQ_PERIPH, SEQ_CORE, SEQ_RUN} sip_seq_t;
  typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} sip_pm_t;
endpackage : sip_pkg

// *** tb/sip_assertions.sv ***
`timescale 1ns/1ns
module sip_assertions
  import sip_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        ext_reset_n_i,
  input wire logic        watchdog_reset_i,
  input wire logic        periph_irq_i,
  input wire logic        can_activity_i,
  input wire logic        external_irq_a_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        core_clk_o,
  input wire logic [15:0] periph_clk_o,
  input wire logic        debug_clk_o,
  input wire logic        periph_rst_n_o,
  input wire logic        core_rst_n_o,
  input wire logic        app_run_o,
  input wire logic        debug_read_dis_o,
  input wire logic        debug_if_dis_o,
  input wire logic        jtag_tap_en_o,
  input wire logic [17:0] short_address_base_o,
  input wire logic [1:0]  power_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i || !ext_reset_n_i);
  wire wr_low  = avs_write_i && !avs_waitrequest_o && avs_address_i == SIP_OFS_SA_LOW;
  wire in_wait = power_mode_o == SIP_MODE_WAIT;
  wire in_stop = power_mode_o == SIP_MODE_STOP;
  wire stop_wk = can_activity_i || external_irq_a_i;
  core_half_a: assert property (core_clk_o |=> !core_clk_o)
    else $error("core clock high two cycles");
  periph_half_a: assert property ((periph_clk_o & $past(periph_clk_o)) == 16'h0000)
    else $error("peripheral clock high two cycles");
  wait_core_off_a: assert property (in_wait && $past(in_wait) |-> !core_clk_o)
    else $error("core clock runs in wait");
  wait_wake_a: assert property (in_wait && periph_irq_i |=> power_mode_o == SIP_MODE_RUN)
    else $error("interrupt did not end wait");
  stop_hold_a: assert property (in_stop && !stop_wk && !watchdog_reset_i |=> in_stop)
    else $error("stop left without wake source");
  stop_wake_a: assert property (in_stop && stop_wk |=> power_mode_o == SIP_MODE_RUN)
    else $error("stop wake did not return to run");
  app_after_rst_a: assert property (app_run_o |-> core_rst_n_o && periph_rst_n_o)
    else $error("application runs in reset");
  core_after_periph_a: assert property ($rose(core_rst_n_o) |-> $past(periph_rst_n_o, 2))
    else $error("core released before peripheral window");
  sa_delay_a: assert property (wr_low |-> ##6
    short_address_base_o[15:0] == $past(avs_writedata_i[15:0], 6))
    else $error("short address late or wrong");
  secure_dbg_a: assert property (debug_if_dis_o |-> debug_read_dis_o && !debug_clk_o)
    else $error("debug open while secure");
  jtag_on_a: assert property (jtag_tap_en_o)
    else $error("test access port off");
  cover property (in_wait ##1 power_mode_o == SIP_MODE_RUN);
  cover property (in_stop ##1 power_mode_o == SIP_MODE_RUN);
  cover property (wr_low);
  cover property ($rose(app_run_o));
endmodule : sip_assertions

bind sip_power_reset sip_assertions u_chk (.clock_i, .reset_n_i, .ext_reset_n_i,
  .watchdog_reset_i, .periph_irq_i, .can_activity_i, .external_irq_a_i, .avs_address_i,
  .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .core_clk_o, .periph_clk_o,
  .debug_clk_o, .periph_rst_n_o, .core_rst_n_o, .app_run_o, .debug_read_dis_o,
  .debug_if_dis_o, .jtag_tap_en_o, .short_address_base_o, .power_mode_o);

// *** tb/sip_core_model.sv ***
`timescale 1ns/1ns
module sip_core_model
  import sip_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       app_run_i,
  input  wire logic [1:0] power_mode_i,
  input  wire logic       req_wait_i,
  input  wire logic       req_stop_i,
  input  wire logic       irq_en_i,
  input  wire logic [3:0] irq_dly_i,
  output logic            wait_instr_o,
  output logic            stop_instr_o,
  output logic            periph_irq_o
);
  logic [3:0] irq_cnt_r;
  wire        waiting = power_mode_i == SIP_MODE_WAIT;
  // sleep opcodes only issue while code runs; pll is left as software set it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_instr_o <= 1'b0;
      stop_instr_o <= 1'b0;
      irq_cnt_r    <= 4'h0;
      periph_irq_o <= 1'b0;
    end else begin
      wait_instr_o <= req_wait_i && app_run_i;
      stop_instr_o <= req_stop_i && app_run_i;
      irq_cnt_r    <= waiting ? irq_cnt_r + 4'h1 : 4'h0;
      periph_irq_o <= irq_en_i && waiting && irq_cnt_r >= irq_dly_i;
    end
  end
endmodule : sip_core_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
  import sip_pkg::*;
  localparam int PC = 2;
  localparam int CC = 2;
  logic        clock_i, reset_n_i, ext_reset_n_i, lv_core_1v8_i, lv_core_2v2_i, lv_io_2v7_i;
  logic        watchdog_reset_i, wait_instr_i, stop_instr_i, periph_irq_i, can_activity_i;
  logic        external_irq_a_i, avs_read_i, avs_write_i, avs_waitrequest_o, core_clk_o;
  logic        watchdog_clk_o, clk_out_o, debug_clk_o, periph_rst_n_o, core_rst_n_o, app_run_o;
  logic        debug_read_dis_o, debug_if_dis_o, jtag_tap_en_o, req_wait, req_stop, irq_en, c;
  logic [7:0]  sec_byte_lo_i, sec_byte_hi_i;
  logic [4:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i, irq_dly;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [15:0] periph_clk_o, q, d, h, gp, seen;
  logic [17:0] short_address_base_o, prev;
  logic [1:0]  power_mode_o;
  int          comparisons, miscompares;
  logic [4:0]  ad [5] = '{SIP_OFS_CTRL, SIP_OFS_PCE, SIP_OFS_SA_HIGH, SIP_OFS_SA_LOW, 5'h14};
  logic [15:0] rv [5] = '{SIP_CTRL_RESET, SIP_PCE_RESET, SIP_SAH_RESET, SIP_SAL_RESET, 16'h0000};

  sip_power_reset #(.STAB_CYCLES(4), .PERIPH_CYCLES(PC), .CORE_CYCLES(CC)) dut (.clock_i,
    .reset_n_i, .ext_reset_n_i, .lv_core_1v8_i, .lv_core_2v2_i, .lv_io_2v7_i, .watchdog_reset_i,
    .wait_instr_i, .stop_instr_i, .periph_irq_i, .can_activity_i, .external_irq_a_i,
    .sec_byte_lo_i, .sec_byte_hi_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .core_clk_o, .periph_clk_o,
    .watchdog_clk_o, .clk_out_o, .debug_clk_o, .periph_rst_n_o, .core_rst_n_o, .app_run_o,
    .debug_read_dis_o, .debug_if_dis_o, .jtag_tap_en_o, .short_address_base_o, .power_mode_o);
  sip_core_model u_core (.clock_i, .reset_n_i, .app_run_i(app_run_o), .power_mode_i(power_mode_o),
    .req_wait_i(req_wait), .req_stop_i(req_stop), .irq_en_i(irq_en), .irq_dly_i(irq_dly),
    .wait_instr_o(wait_instr_i), .stop_instr_o(stop_instr_i), .periph_irq_o(periph_irq_i));

  function automatic logic [15:0] pce_exp(input logic [15:0] v);
    return (v & SIP_PCE_WMASK) | ~SIP_PCE_WMASK;
  endfunction : pce_exp

  // no local limit: only the watchdog may end a hung transfer
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] v);
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= {16'h0000, v};
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[15:0];
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wait_rise(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
  endtask : wait_rise

  // restart of the staged release after any reset source
  task automatic rst_seq;
    int n;
    n = 0;
    while (app_run_o === 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    wait_rise(periph_rst_n_o, n);
    wait_rise(core_rst_n_o, n);
    `CHK(n, PC)
    wait_rise(app_run_o, n);
    `CHK(n, CC)
  endtask : rst_seq

  // xe holds the expected {watchdog, clock out, debug} activity
  task automatic clocks(input logic [15:0] pe, input logic ce, input logic [2:0] xe);
    logic [2:0] x;
    seen = 16'h0000;
    c = 1'b0;
    x = 3'b000;
    repeat (4) begin
      @(posedge clock_i);
      seen |= periph_clk_o;
      c |= core_clk_o;
      x |= {watchdog_clk_o, clk_out_o, debug_clk_o};
    end
    `CHK(seen, pe)
    `CHK(c, ce)
    `CHK(x, xe)
  endtask : clocks

  task automatic sleep(input logic stp, input logic [1:0] m);
    @(posedge clock_i);
    req_stop <= stp;
    req_wait <= !stp;
    @(posedge clock_i);
    req_stop <= 1'b0;
    req_wait <= 1'b0;
    repeat (3) @(posedge clock_i);
    `CHK(power_mode_o, m)
  endtask : sleep

  task automatic until_run;
    int n;
    n = 0;
    while (power_mode_o !== SIP_MODE_RUN && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    `CHK(power_mode_o, SIP_MODE_RUN)
  endtask : until_run

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    conclude();
  end

  initial begin
    {reset_n_i, watchdog_reset_i, can_activity_i, external_irq_a_i} = 4'h0;
    {ext_reset_n_i, lv_core_1v8_i, lv_core_2v2_i, lv_io_2v7_i} = 4'hF;
    {avs_read_i, avs_write_i, req_wait, req_stop, irq_en} = 5'h00;
    {sec_byte_hi_i, sec_byte_lo_i} = SIP_SEC_ON_WORD;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    irq_dly = 4'h0;
    void'($urandom(57));
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    lv_core_2v2_i <= 1'b0;
    lv_io_2v7_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    `CHK(periph_rst_n_o, 1'b0)
    lv_core_1v8_i <= 1'b0;
    rst_seq();
    `CHK(debug_if_dis_o, 1'b1)
    `CHK(debug_read_dis_o, 1'b1)
    `CHK(jtag_tap_en_o, 1'b1)
    bus(1'b1, 5'h14, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ad[i], 16'h0000);
      `CHK(q, rv[i])
    end
    bus(1'b1, SIP_OFS_CTRL, 16'h0040);
    prev = 18'h3_FFFF;
    repeat (3) begin
      d = 16'($urandom);
      gp = pce_exp(d);
      bus(1'b1, SIP_OFS_PCE, d);
      bus(1'b0, SIP_OFS_PCE, 16'h0000);
      `CHK(q, gp)
      clocks(gp, 1'b1, 3'b110);
      h = 16'($urandom);
      d = 16'($urandom);
      bus(1'b1, SIP_OFS_SA_HIGH, h);
      bus(1'b1, SIP_OFS_SA_LOW, d);
      prev = {h[1:0], prev[15:0]};
      repeat (5) @(posedge clock_i);
      `CHK(short_address_base_o, prev)
      @(posedge clock_i);
      prev = {h[1:0], d};
      `CHK(short_address_base_o, prev)
      bus(1'b0, SIP_OFS_SA_HIGH, 16'h0000);
      `CHK(q, {14'h3FFF, h[1:0]})
    end
    sleep(1'b0, SIP_MODE_WAIT);
    clocks(gp, 1'b0, 3'b110);
    irq_dly <= 4'($urandom_range(7, 0));
    irq_en <= 1'b1;
    until_run();
    irq_en <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      sleep(1'b1, SIP_MODE_STOP);
      clocks(16'h0000, 1'b0, 3'b110);
      `CHK(power_mode_o, SIP_MODE_STOP)
      if (i == 0) can_activity_i <= 1'b1;
      else external_irq_a_i <= 1'b1;
      @(posedge clock_i);
      can_activity_i <= 1'b0;
      external_irq_a_i <= 1'b0;
      until_run();
    end
    bus(1'b1, SIP_OFS_CTRL, 16'h0001);
    sleep(1'b0, SIP_MODE_RUN);
    bus(1'b1, SIP_OFS_CTRL, 16'h0008);
    bus(1'b1, SIP_OFS_CTRL, 16'h0000);
    bus(1'b0, SIP_OFS_STATUS, 16'h0000);
    `CHK(q[SIP_ST_STOP_DIS], 1'b1)
    sleep(1'b1, SIP_MODE_RUN);
    {sec_byte_hi_i, sec_byte_lo_i} <= ~SIP_SEC_ON_WORD;
    bus(1'b1, SIP_OFS_CTRL, 16'h0010);
    rst_seq();
    bus(1'b0, SIP_OFS_STATUS, 16'h0000);
    `CHK(q[6:5], 2'b00)
    `CHK(q[4:0], 5'h10)
    `CHK(debug_if_dis_o, 1'b0)
    watchdog_reset_i <= 1'b1;
    @(posedge clock_i);
    watchdog_reset_i <= 1'b0;
    rst_seq();
    ext_reset_n_i <= 1'b0;
    #1;
    `CHK(app_run_o, 1'b0)
    @(posedge clock_i);
    ext_reset_n_i <= 1'b1;
    rst_seq();
    bus(1'b1, SIP_OFS_CTRL, 16'h0060);
    bus(1'b0, SIP_OFS_CTRL, 16'h0000);
    `CHK(q, 16'h0060)
    clocks(SIP_PCE_RESET, 1'b1, 3'b101);
    lv_io_2v7_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    `CHK(app_run_o, 1'b1)
    lv_core_1v8_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    `CHK(app_run_o, 1'b0)
    lv_core_1v8_i <= 1'b0;
    lv_io_2v7_i <= 1'b0;
    rst_seq();
    conclude();
  end
endmodule : testbench
